// [rtl/wdt_pkg.sv]
/*
  Shared constants and carrier types for the windowed watchdog timer.
  Assumes a single 125 MHz clock (mclk) and an asynchronous active-high reset.
*/
package wdt_pkg;

  // nominal low-power oscillator rate and derived tick spacing in mclk cycles
  localparam int OSC_FREQ_HZ = 32000;
  localparam int MCLK_FREQ_HZ = 125000000;
  localparam int OSC_DIV_CYCLES = MCLK_FREQ_HZ / OSC_FREQ_HZ; // rounds down
  localparam logic [12:0] OSC_TICK_LAST = 13'(OSC_DIV_CYCLES - 1);

  // prescaler ratios: 5-bit or 7-bit mode
  localparam logic [6:0] PRE_LAST_DIV32 = 7'h1f;
  localparam logic [6:0] PRE_LAST_DIV128 = 7'h7f;

  // nominal base timeouts in microseconds for each prescale choice
  localparam int BASE_TIMEOUT_DIV32_US = 1000;
  localparam int BASE_TIMEOUT_DIV128_US = 4000;

  // postscaler width: 16 ratios, 1:1 .. 1:32768
  localparam int POST_WIDTH = 15;

  // window opens in the last quarter of the period
  localparam int WINDOW_SHIFT = 2;

  // reset values
  localparam logic RST_SOFT_ENABLE = 1'b0;
  localparam logic RST_TIMEOUT_FLAG = 1'b0;

  // configuration bits as loaded from the watchdog configuration word
  typedef struct packed {
    logic watchdogAlwaysOn;
    logic windowModeDisable;
    logic watchdogPrescaleSelect;
    logic [3:0] watchdogPostscaleSelect;
  } watchdog_config_type;

  // one-cycle core events that clear the counters
  typedef struct packed {
    logic clearWatchdogInstr;
    logic powerSaveInstr;
    logic powerSaveExit;
    logic clockSwitchDone;
  } core_event_type;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_SAVE = 2'b11
  } wdt_state_type;

  // selected postscale terminal count (ratio minus one)
  function automatic logic [POST_WIDTH-1:0] post_last(input logic [3:0] sel);
    post_last = POST_WIDTH'((32'h1 << sel) - 32'h1);
  endfunction : post_last

endpackage : wdt_pkg

// [rtl/low_power_rc_osc_tick_gen.sv]
/*
  Models the low-power RC oscillator as a tick strobe derived from mclk.
  Assumes mclk at 125 MHz; the oscillator runs only while forced on.
*/
`timescale 1ns/100ps
module osc_tick_gen
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic oscOn,
  output logic oscTick
);
  import wdt_pkg::*;

  logic [12:0] divCount_r;

  // free divider, parked at zero while the oscillator is off to save power
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCount_r <= 13'h0000;
      oscTick <= 1'b0;
    end else if (!oscOn) begin
      divCount_r <= 13'h0000;
      oscTick <= 1'b0;
    end else if (divCount_r == OSC_TICK_LAST) begin
      divCount_r <= 13'h0000;
      oscTick <= 1'b1;
    end else begin
      divCount_r <= divCount_r + 13'h0001;
      oscTick <= 1'b0;
    end
  end

endmodule : osc_tick_gen

// [rtl/windowed_watchdog_timer.sv]
/*
  Windowed watchdog: prescaler, postscaler, timeout flag, wake and reset requests.
  Assumes configuration bits are stable and core events are one-cycle pulses
  synchronous to mclk; watchdogReset is fed back on rst by the system reset logic.
*/
`timescale 1ns/100ps
// What this block does
// [RULE1] counter runs from low-power oscillator, forced on
// [RULE2] prescaler divides by 32 or 128
// [RULE3] base timeout about 1 ms or 4 ms
// [RULE4] 4-bit postscaler selects sixteen ratios
// [RULE5] any device reset clears all counts
// [RULE6] completed clock switch clears all counts
// [RULE7] entering sleep or idle clears counts
// [RULE8] leaving sleep or idle clears counts
// [RULE9] clear instruction clears counter and scalers
// [RULE10] counts in sleep, timeout wakes device
// [RULE11] software clears sleep and idle bits afterwards; no such bits exist in this block
// [RULE12] always-on bit forces watchdog enabled
// [RULE13] otherwise soft enable bit starts/stops it
// [RULE14] soft enable cleared by any reset
// [RULE15] software clears only in last quarter
// [RULE16] early clear in window mode resets device
// [RULE17] timeout flag sticky until software clears; here rst also clears it, including the fed-back watchdog reset
// [RULE18] prescale bit one selects 128, zero 32
// [RULE19] postscale value n gives ratio 2^n
// [RULE20] window-disable one means non-window mode
// [RULE21] running timeout resets device, sets flag
// [RULE22] disabled watchdog holds counts at zero, no events
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wdt_pkg::watchdog_config_type cfg,
  input wdt_pkg::core_event_type coreEvent,
  input wire logic inPowerSave,
  input wire logic softEnableSet,
  input wire logic softEnableClear,
  input wire logic timeoutFlagClear,
  output logic watchdogSoftEnable,
  output logic watchdogTimeoutFlag,
  output logic lowPowerOscOn,
  output logic watchdogReset,
  output logic watchdogWake,
  output logic windowOpen
);
  import wdt_pkg::*;

  logic oscTick;
  logic wdtEnabled;
  logic clearCounts;
  logic [6:0] preCount_r;
  logic [POST_WIDTH-1:0] postCount_r;
  logic [6:0] preLast;
  logic [POST_WIDTH-1:0] postLast;
  logic expire;
  logic earlyClear;
  logic [POST_WIDTH+6:0] elapsed;
  logic [POST_WIDTH+6:0] periodLast;
  wdt_state_type state_r, state_nxt;

  // joins both scaler counts into one tick count of the whole period;
  // in 5-bit mode the two upper prescale bits are never used, so drop them
  function automatic logic [POST_WIDTH+6:0] span_of(
    input logic div128,
    input logic [POST_WIDTH-1:0] post,
    input logic [6:0] pre
  );
    span_of = div128 ? {post, pre} : {2'h0, post, pre[4:0]};
  endfunction : span_of

  // always-on overrides software control
  assign wdtEnabled = cfg.watchdogAlwaysOn | watchdogSoftEnable; // [RULE12] [RULE13]
  assign lowPowerOscOn = wdtEnabled; // [RULE1]

  osc_tick_gen osc_tick_gen_inst (
    .mclk(mclk),
    .rst(rst),
    .oscOn(lowPowerOscOn),
    .oscTick(oscTick)
  );

  // prescale: 1 selects 1:128 (about 4 ms), 0 selects 1:32 (about 1 ms)
  assign preLast = cfg.watchdogPrescaleSelect ? PRE_LAST_DIV128 : PRE_LAST_DIV32; // [RULE2] [RULE18] [RULE3]
  assign postLast = post_last(cfg.watchdogPostscaleSelect); // [RULE4] [RULE19]

  // window opens once 3/4 of the whole period has elapsed; judging on the
  // postscaler alone would open at half time for the 1:2 ratio
  assign elapsed = span_of(cfg.watchdogPrescaleSelect, postCount_r, preCount_r);
  assign periodLast = span_of(cfg.watchdogPrescaleSelect, postLast, preLast);
  assign windowOpen = wdtEnabled &&
    (elapsed >= (periodLast - (periodLast >> WINDOW_SHIFT))); // [RULE16]
  // early clear only matters in window mode and normal execution
  assign earlyClear = wdtEnabled && !cfg.windowModeDisable && // [RULE20]
    coreEvent.clearWatchdogInstr && !inPowerSave && !windowOpen; // [RULE16]

  // any of these restarts the whole chain
  assign clearCounts = coreEvent.clockSwitchDone | // [RULE6]
    coreEvent.powerSaveInstr | // [RULE7]
    coreEvent.powerSaveExit | // [RULE8]
    (coreEvent.clearWatchdogInstr && !inPowerSave) | // [RULE9]
    !wdtEnabled; // [RULE22]

  assign expire = wdtEnabled && oscTick && !clearCounts &&
    (preCount_r == preLast) && (postCount_r == postLast);

  // state tracks disabled, normal run and power-save counting
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: if (wdtEnabled) state_nxt = inPowerSave ? ST_SAVE : ST_RUN;
      ST_RUN: begin
        if (!wdtEnabled) state_nxt = ST_OFF;
        else if (inPowerSave) state_nxt = ST_SAVE;
      end
      ST_SAVE: begin
        if (!wdtEnabled) state_nxt = ST_OFF;
        else if (!inPowerSave) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // prescaler and postscaler; device reset (rst) clears both
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin // [RULE5]
      preCount_r <= 7'h00;
      postCount_r <= '0;
    end else if (clearCounts || expire) begin
      preCount_r <= 7'h00;
      postCount_r <= '0;
    end else if (oscTick) begin
      if (preCount_r == preLast) begin
        preCount_r <= 7'h00;
        postCount_r <= postCount_r + POST_WIDTH'(1);
      end else begin
        preCount_r <= preCount_r + 7'h01;
      end
    end
  end

  // timeout in power save wakes; in normal run it resets (one-cycle pulses)
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      watchdogWake <= 1'b0;
      watchdogReset <= 1'b0;
    end else begin
      watchdogWake <= expire && inPowerSave; // [RULE10]
      watchdogReset <= (expire && !inPowerSave) || earlyClear; // [RULE21] [RULE16]
    end
  end

  // software enable: set wins over clear, reset clears it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) watchdogSoftEnable <= RST_SOFT_ENABLE; // [RULE14]
    else if (softEnableSet) watchdogSoftEnable <= 1'b1; // [RULE13]
    else if (softEnableClear) watchdogSoftEnable <= 1'b0;
  end

  // sticky flag; a timeout in the same cycle as the clear wins. the flag is
  // cleared by rst, so the watchdog reset it causes clears it once fed back on rst
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) watchdogTimeoutFlag <= RST_TIMEOUT_FLAG;
    else if (expire || earlyClear) watchdogTimeoutFlag <= 1'b1; // [RULE17]
    else if (timeoutFlagClear) watchdogTimeoutFlag <= 1'b0;
  end

  sequence seq_expire_run;
    expire && !inPowerSave;
  endsequence

  sequence seq_clear_in_run;
    coreEvent.clearWatchdogInstr && !inPowerSave;
  endsequence

  AST_RESET_ON_TIMEOUT: assert property (@(posedge mclk) disable iff (rst) // [RULE21]
    seq_expire_run |=> watchdogReset && watchdogTimeoutFlag)
    else $error("timeout in run did not reset");
  AST_WAKE_IN_SAVE: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
    expire && inPowerSave |=> watchdogWake && !watchdogReset)
    else $error("timeout in power save did not wake");
  AST_EARLY_CLEAR: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    wdtEnabled && !cfg.windowModeDisable && coreEvent.clearWatchdogInstr
    && !inPowerSave && !windowOpen |=> watchdogReset)
    else $error("early clear did not reset");
  AST_NONWINDOW_NO_RESET: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
    cfg.windowModeDisable && coreEvent.clearWatchdogInstr && !expire |=> !watchdogReset)
    else $error("clear in non-window mode reset");
  AST_DISABLED_HOLD: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
    !wdtEnabled |=> preCount_r == 7'h00 && postCount_r == '0 && !watchdogReset)
    else $error("disabled watchdog counted");
  AST_CLEAR_EVENTS: assert property (@(posedge mclk) disable iff (rst) // [RULE6] [RULE7] [RULE8]
    coreEvent.clockSwitchDone || coreEvent.powerSaveInstr || coreEvent.powerSaveExit
    |=> preCount_r == 7'h00 && postCount_r == '0)
    else $error("counts not cleared by event");
  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
    watchdogTimeoutFlag && !timeoutFlagClear |=> watchdogTimeoutFlag)
    else $error("timeout flag dropped");
  AST_OSC_FORCED: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
    cfg.watchdogAlwaysOn |-> lowPowerOscOn)
    else $error("oscillator off while always on");
  AST_PRESCALE_WRAP: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
    oscTick && !clearCounts && !expire && preCount_r == preLast
    |=> preCount_r == 7'h00 && postCount_r == $past(postCount_r) + POST_WIDTH'(1))
    else $error("prescaler did not wrap");
  AST_SOFT_ENABLE: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
    softEnableSet |=> watchdogSoftEnable)
    else $error("soft enable not set");
  AST_CLEAR_INSTR: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
    seq_clear_in_run |=> preCount_r == 7'h00 && postCount_r == '0)
    else $error("clear instruction left counts");
  AST_WINDOW_SHUT: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    seq_clear_in_run |=> !windowOpen)
    else $error("window open right after clear");
  AST_STATE_OFF: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
    !wdtEnabled |=> state_r == ST_OFF)
    else $error("state not off while disabled");
  AST_STATE_SAVE: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
    wdtEnabled && inPowerSave |=> state_r == ST_SAVE)
    else $error("state not tracking power save");
  AST_NO_SPURIOUS_WAKE: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
    !(expire && inPowerSave) |=> !watchdogWake)
    else $error("wake without timeout");

endmodule : windowed_watchdog_timer

// [tb/windowed_watchdog_timer_tb.sv]
/*
  Self-checking bench for the windowed watchdog: enables, early clears, flag,
  and one walk up to the clear window. Assumes 125 MHz mclk; the window walk
  waits 24 oscillator ticks (about 94k cycles), so full timeouts stay out of reach.
*/
`timescale 1ns/100ps
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  watchdog_config_type cfg = '0;
  core_event_type coreEvent = '0;
  logic inPowerSave = 1'b0;
  logic softEnableSet = 1'b0;
  logic softEnableClear = 1'b0;
  logic timeoutFlagClear = 1'b0;
  logic watchdogSoftEnable, watchdogTimeoutFlag, lowPowerOscOn;
  logic watchdogReset, watchdogWake, windowOpen;
  logic expQ[$];
  int num_errors = 0;
  int comparisons = 0;
  localparam core_event_type CLR = 4'h8;
  // window opens after three quarters of the 32 prescale ticks (1:1 postscale)
  localparam int OPEN_TICKS = (int'(PRE_LAST_DIV32) + 1) * 3 / 4;
  localparam int WAIT_LIMIT = OPEN_TICKS * OSC_DIV_CYCLES;
  int waited;

  windowed_watchdog_timer windowed_watchdog_timer_inst (
    .mclk(mclk), .rst(rst), .cfg(cfg), .coreEvent(coreEvent),
    .inPowerSave(inPowerSave), .softEnableSet(softEnableSet),
    .softEnableClear(softEnableClear), .timeoutFlagClear(timeoutFlagClear),
    .watchdogSoftEnable(watchdogSoftEnable), .watchdogTimeoutFlag(watchdogTimeoutFlag),
    .lowPowerOscOn(lowPowerOscOn), .watchdogReset(watchdogReset),
    .watchdogWake(watchdogWake), .windowOpen(windowOpen)
  );

  // 8 ns period
  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic seen, input logic exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check

  // one-cycle pulses; sw is {set, clear, flag clear}; settle before return
  task automatic drive(input core_event_type ev, input logic [2:0] sw);
    @(posedge mclk);
    coreEvent <= ev;
    {softEnableSet, softEnableClear, timeoutFlagClear} <= sw;
    @(posedge mclk);
    coreEvent <= '0;
    {softEnableSet, softEnableClear, timeoutFlagClear} <= 3'h0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : drive

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // every reset pulse consumes the oldest note; flag is set on the same edge
  always @(negedge mclk) begin
    if (watchdogReset === 1'b1) begin
      if (expQ.size() == 0) check(watchdogReset, 1'b0, "unexpected reset");
      else check(watchdogTimeoutFlag, expQ.pop_front(), "flag with reset");
    end
    check(watchdogWake, 1'b0, "unexpected wake");
  end

  // window walk takes at most about 94k cycles, the rest a few hundred
  initial begin
    #790000;
    num_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hb5bd));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(watchdogSoftEnable, 1'b0, "soft enable after reset");
    check(watchdogTimeoutFlag, 1'b0, "flag after reset");
    check(lowPowerOscOn, 1'b0, "osc off when disabled");
    // disabled: early clear in window mode must do nothing
    drive(CLR, 3'h0);
    check(windowOpen, 1'b0, "window shut while disabled");
    $display("test reset_and_disabled done");
    // set beats clear in the same cycle
    drive('0, 3'b110);
    check(watchdogSoftEnable, 1'b1, "soft set wins");
    check(lowPowerOscOn, 1'b1, "osc forced on");
    // random scaler settings; counts are fresh, so the window is shut
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      cfg.watchdogPrescaleSelect <= 1'($urandom);
      cfg.watchdogPostscaleSelect <= 4'($urandom_range(15, 1));
      expQ.push_back(1'b1);
      drive(CLR, 3'h0);
      check(windowOpen, 1'b0, "window open after clear");
      check(watchdogTimeoutFlag, 1'b1, "flag sticky");
      drive('0, 3'b001);
      check(watchdogTimeoutFlag, 1'b0, "flag cleared");
    end
    expQ.push_back(1'b1);
    drive(CLR, 3'b001);
    check(watchdogTimeoutFlag, 1'b1, "flag set beats clear");
    drive('0, 3'b001);
    $display("test early_clear done");
    // non-window mode ignores early clears
    @(posedge mclk);
    cfg.windowModeDisable <= 1'b1;
    drive(CLR, 3'h0);
    @(posedge mclk);
    cfg.windowModeDisable <= 1'b0;
    // clear during power save is refused; other events clear counts only
    inPowerSave <= 1'b1;
    drive(4'h4, 3'h0);
    drive(CLR, 3'h0);
    @(posedge mclk);
    inPowerSave <= 1'b0;
    drive(4'h2, 3'h0);
    drive(4'h1, 3'h0);
    check(watchdogTimeoutFlag, 1'b0, "no flag from refused clear");
    $display("test modes done");
    // shortest period: 1:32 prescale, 1:1 postscale, window mode
    @(posedge mclk);
    cfg.watchdogPrescaleSelect <= 1'b0;
    cfg.watchdogPostscaleSelect <= 4'h0;
    drive(4'h1, 3'h0);
    // tick phase is free, so the opening is known to within one tick
    for (waited = 0; waited < WAIT_LIMIT && windowOpen !== 1'b1; waited++) begin
      @(negedge mclk);
    end
    check(windowOpen, 1'b1, "window never opened");
    check(waited >= (OPEN_TICKS - 1) * OSC_DIV_CYCLES - 4, 1'b1, "window early");
    // a clear inside the window must not reset, and restarts the period
    drive(CLR, 3'h0);
    check(windowOpen, 1'b0, "window open after in-window clear");
    check(watchdogTimeoutFlag, 1'b0, "flag from in-window clear");
    $display("test window done");
    drive('0, 3'b010);
    check(watchdogSoftEnable, 1'b0, "soft cleared");
    check(lowPowerOscOn, 1'b0, "osc off again");
    // always-on overrides the soft bit
    @(posedge mclk);
    cfg.watchdogAlwaysOn <= 1'b1;
    expQ.push_back(1'b1);
    drive(CLR, 3'b010);
    check(lowPowerOscOn, 1'b1, "always on osc");
    @(posedge mclk);
    cfg.watchdogAlwaysOn <= 1'b0;
    drive('0, 3'b100);
    // mid-run reset wipes soft enable and flag
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(watchdogSoftEnable, 1'b0, "soft after mid reset");
    check(watchdogTimeoutFlag, 1'b0, "flag after mid reset");
    check(expQ.size() == 0, 1'b1, "missing reset pulse");
    $display("test always_on_and_reset done");
    give_verdict();
  end
endmodule : windowed_watchdog_timer_tb
